// ---- include/avo_pkg.sv ----
/*
 * Constants, types and decode helpers for the right-channel volume and
 * output-stage configuration register slice of the stereo amplifier.
 * Assumes the control-port engine hands over byte-wide register accesses
 * in the control-logic clock domain.
 */
package avo_pkg;

	// Register offsets
	localparam logic [7:0] AVO_OFS_RIGHT_GAIN   = 8'h05;
	localparam logic [7:0] AVO_OFS_OUTPUT_CFG   = 8'h06;
	localparam logic [7:0] AVO_OFS_RESERVED_SEV = 8'h07;

	// Reset values
	localparam logic [7:0] AVO_RST_RIGHT_GAIN = 8'hCF;
	localparam logic [7:0] AVO_RST_OUTPUT_CFG = 8'h51;

	// Field positions in the output stage configuration register
	localparam int AVO_BIT_PARALLEL = 7;
	localparam int AVO_POS_RATE_HI  = 6;
	localparam int AVO_POS_RATE_LO  = 4;
	localparam int AVO_POS_AGAIN_HI = 3;
	localparam int AVO_POS_AGAIN_LO = 2;
	localparam int AVO_BIT_MONO_SRC = 1;

	// Lowest code that still plays; anything below mutes
	localparam logic [7:0] AVO_MUTE_LIMIT = 8'h07;

	// Register access handed over by the control port
	typedef struct packed {
		logic       wr;    // Write strobe, one cycle
		logic       rd;    // Read strobe, one cycle
		logic [7:0] addr;  // Register offset
		logic [7:0] wdata; // Write data
	} avo_req_t;

	// Decoded settings seen by the audio path
	typedef struct packed {
		logic signed [8:0] gain_half_db;   // Gain in 0.5 dB steps
		logic              mute;           // Channel muted by code
		logic              parallel_mono;  // Parallel bridge mono
		logic              mono_src_left;  // Mono fed from left
		logic        [4:0] switch_mult;    // Switching per frame
		logic        [1:0] analog_gain;    // Analog gain select
		logic              double_speed;   // Double-speed rates
	} avo_cfg_t;

	// Switching rate multiple of the frame clock, single speed
	function automatic logic [4:0] avo_rate_mult(input logic [2:0] code);
		logic [4:0] m;
		m = 5'h06;
		case (code)
			3'h0: m = 5'h06;
			3'h1: m = 5'h08;
			3'h2: m = 5'h0A;
			3'h3: m = 5'h0C;
			3'h4: m = 5'h0E;
			3'h5: m = 5'h10;
			3'h6: m = 5'h14;
			3'h7: m = 5'h18;
		endcase
		return m;
	endfunction

endpackage

// ---- design/avo_regs.sv ----
/*
 * Right-channel volume and output-stage configuration registers,
 * with decode of the settings for the audio and output stages.
 * Assumes the serial control-port engine decodes its frames into
 * single-cycle read and write strobes on mclk, and that the speed
 * select bit is driven from the format register on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module avo_regs (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire avo_pkg::avo_req_t req,
	input  wire logic             sample_speed_range,
	output var  logic [7:0]       rdata_q,
	output var  logic             rvalid_q,
	output var  logic [7:0]       right_gain_q,
	output var  logic [7:0]       output_cfg_q,
	output var  avo_pkg::avo_cfg_t cfg_q
);

	// Next values of the stored registers
	logic [7:0]        right_gain_d;  // Volume code
	logic [7:0]        output_cfg_d;  // Output stage settings
	logic [7:0]        rdata_d;       // Read data
	logic              rvalid_d;      // Read answer strobe
	avo_pkg::avo_cfg_t cfg_d;         // Decoded settings
	logic [4:0]        rate_full;     // Single-speed switching multiple

	// Register writes and read answers
	always_comb begin
		right_gain_d = right_gain_q;
		output_cfg_d = output_cfg_q;
		rdata_d      = 8'h00;
		rvalid_d     = req.rd;
		if (req.wr) begin
			// Writes to the reserved slot and unmapped offsets are dropped
			if (req.addr == avo_pkg::AVO_OFS_RIGHT_GAIN) begin
				right_gain_d = req.wdata;
			end else if (req.addr == avo_pkg::AVO_OFS_OUTPUT_CFG) begin
				output_cfg_d = req.wdata;
			end
		end
		if (req.rd) begin
			// Reserved slot and unmapped offsets read as zero
			if (req.addr == avo_pkg::AVO_OFS_RIGHT_GAIN) begin
				rdata_d = right_gain_q;
			end else if (req.addr == avo_pkg::AVO_OFS_OUTPUT_CFG) begin
				rdata_d = output_cfg_q;
			end else begin
				rdata_d = 8'h00;
			end
		end
	end

	// Register storage
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			right_gain_q <= avo_pkg::AVO_RST_RIGHT_GAIN;
			output_cfg_q <= avo_pkg::AVO_RST_OUTPUT_CFG;
			rdata_q      <= 8'h00;
			rvalid_q     <= 1'b0;
		end else begin
			right_gain_q <= right_gain_d;
			output_cfg_q <= output_cfg_d;
			rdata_q      <= rdata_d;
			rvalid_q     <= rvalid_d;
		end
	end

	// Speed select synchroniser is not needed: same clock domain
	// Decode of the stored settings
	always_comb begin
		cfg_d = '0;
		// Code 0xCF is unity; each step is 0.5 dB
		cfg_d.gain_half_db = $signed({1'b0, right_gain_q})
			- $signed({1'b0, avo_pkg::AVO_RST_RIGHT_GAIN});
		cfg_d.mute = (right_gain_q < avo_pkg::AVO_MUTE_LIMIT);
		cfg_d.parallel_mono =
			output_cfg_q[avo_pkg::AVO_BIT_PARALLEL];
		// Source choice only matters in mono mode; right when clear
		cfg_d.mono_src_left =
			output_cfg_q[avo_pkg::AVO_BIT_PARALLEL]
			& output_cfg_q[avo_pkg::AVO_BIT_MONO_SRC];
		cfg_d.double_speed = sample_speed_range;
		// Multiple for single speed; held apart so it can be halved
		rate_full = avo_pkg::avo_rate_mult(
			output_cfg_q[avo_pkg::AVO_POS_RATE_HI:
			avo_pkg::AVO_POS_RATE_LO]);
		// Double speed keeps the same code but halves the multiple
		if (sample_speed_range) begin
			cfg_d.switch_mult = {1'b0, rate_full[4:1]};
		end else begin
			cfg_d.switch_mult = rate_full;
		end
		cfg_d.analog_gain = output_cfg_q[avo_pkg::AVO_POS_AGAIN_HI:
			avo_pkg::AVO_POS_AGAIN_LO];
	end

	// Decoded settings register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= '0;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	default clocking avo_cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// A write strobe to either live slot
	sequence s_gain_wr;
		req.wr && req.addr == avo_pkg::AVO_OFS_RIGHT_GAIN;
	endsequence

	sequence s_cfg_wr;
		req.wr && req.addr == avo_pkg::AVO_OFS_OUTPUT_CFG;
	endsequence

	// A read strobe of either live slot
	sequence s_gain_rd;
		req.rd && req.addr == avo_pkg::AVO_OFS_RIGHT_GAIN;
	endsequence

	sequence s_cfg_rd;
		req.rd && req.addr == avo_pkg::AVO_OFS_OUTPUT_CFG;
	endsequence

	AST_GAIN_DB: assert property (
		s_gain_wr ##2 1'b1 |-> cfg_q.gain_half_db ==
			$signed({1'b0, $past(req.wdata, 2)}) - 9'sd207)
		else $error("Volume decode wrong after write");

	AST_GAIN_RESET: assert property (
		$rose(rst_n) |-> right_gain_q == 8'hCF)
		else $error("Volume reset value wrong");

	AST_MUTE: assert property (
		s_gain_wr ##2 1'b1 |->
			cfg_q.mute == ($past(req.wdata, 2) < 8'h07))
		else $error("Mute threshold wrong");

	AST_PARALLEL: assert property (
		s_cfg_wr ##2 1'b1 |-> cfg_q.parallel_mono == $past(req.wdata[7], 2))
		else $error("Output topology not following bit 7");

	AST_RATE: assert property (
		!sample_speed_range ##1 1'b1 |-> cfg_q.switch_mult ==
			avo_pkg::avo_rate_mult($past(output_cfg_q[6:4])))
		else $error("Switching rate wrong in single speed");

	AST_RATE_HALF: assert property (
		sample_speed_range ##1 1'b1 |-> 5'(cfg_q.switch_mult * 2) ==
			avo_pkg::avo_rate_mult($past(output_cfg_q[6:4])))
		else $error("Switching rate not halved in double speed");

	AST_AGAIN: assert property (
		s_cfg_wr ##2 1'b1 |-> cfg_q.analog_gain == $past(req.wdata[3:2], 2))
		else $error("Analog gain select wrong");

	AST_MONO_SRC: assert property (
		cfg_q.mono_src_left |-> cfg_q.parallel_mono)
		else $error("Left source chosen outside mono mode");

	AST_RSVD_READ: assert property (
		req.rd && req.addr == avo_pkg::AVO_OFS_RESERVED_SEV
			|=> rvalid_q && rdata_q == 8'h00)
		else $error("Reserved slot did not read zero");

	AST_SPEED: assert property (
		1'b1 ##1 1'b1 |-> cfg_q.double_speed == $past(sample_speed_range))
		else $error("Speed select not carried");

	AST_MONO_FOLLOW: assert property (
		s_cfg_wr ##2 1'b1 |-> cfg_q.mono_src_left ==
			($past(req.wdata[7], 2) && $past(req.wdata[1], 2)))
		else $error("Mono source not following bit 1");

	// Each output-stage field comes out of reset at its default
	AST_TOPO_RESET: assert property (
		$rose(rst_n) |-> !output_cfg_q[7])
		else $error("Output topology reset value wrong");

	AST_RATE_RESET: assert property (
		$rose(rst_n) |-> output_cfg_q[6:4] == 3'h5)
		else $error("Switching rate reset value wrong");

	AST_AGAIN_RESET: assert property (
		$rose(rst_n) |-> output_cfg_q[3:2] == 2'h0)
		else $error("Analog gain reset value wrong");

	AST_SRC_RESET: assert property (
		$rose(rst_n) |-> !output_cfg_q[1])
		else $error("Mono source reset value wrong");

	// Stored settings only move on a write to their own slot
	AST_GAIN_HOLD: assert property (
		!(req.wr && req.addr == avo_pkg::AVO_OFS_RIGHT_GAIN)
			|=> $stable(right_gain_q))
		else $error("Volume changed without a write");

	AST_CFG_HOLD: assert property (
		!(req.wr && req.addr == avo_pkg::AVO_OFS_OUTPUT_CFG)
			|=> $stable(output_cfg_q))
		else $error("Output config changed without a write");

	// Read answers carry the value held at the read edge
	AST_RD_GAIN: assert property (
		s_gain_rd |=> rvalid_q && rdata_q == $past(right_gain_q))
		else $error("Volume read back wrong");

	AST_RD_CFG: assert property (
		s_cfg_rd |=> rvalid_q && rdata_q == $past(output_cfg_q))
		else $error("Output config read back wrong");

	// No answer strobe without a read
	AST_RD_IDLE: assert property (
		!req.rd |=> !rvalid_q)
		else $error("Read answer without a read");

endmodule

`default_nettype wire

// ---- dv/avo_regs_test.sv ----
/* Self-checking bench for the volume and output-stage register slice.
   Assumes avo_pkg is compiled first; registers are reached by strobes. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
	tests_run++; \
	if ((a) !== (e)) begin \
		err_total++; \
		$display("Error %0t: got %h want %h", $time, a, e); \
	end \
end

module avo_regs_test;
	logic              mclk = 1'b0;   // Control clock
	logic              rst_n = 1'b0;  // Reset, active low
	avo_pkg::avo_req_t req = '0;      // Access strobes
	logic              spd = 1'b0;    // Double-speed select
	logic [7:0]        rdata_q;       // Read data
	logic              rvalid_q;      // Read answer
	logic [7:0]        right_gain_q;  // Stored volume
	logic [7:0]        output_cfg_q;  // Stored output config
	avo_pkg::avo_cfg_t cfg_q;         // Decoded settings
	int                err_total = 0; // Mismatches
	int                tests_run = 0; // Comparisons
	int                cyc = 0;       // Cycles run
	logic [4:0]        mult [8] = '{5'h06, 5'h08, 5'h0A, 5'h0C,
		5'h0E, 5'h10, 5'h14, 5'h18};

	// Free-running 25 MHz clock
	always #20 mclk = ~mclk;

	avo_regs dut_u (
		.mclk               (mclk),
		.rst_n              (rst_n),
		.req                (req),
		.sample_speed_range (spd),
		.rdata_q            (rdata_q),
		.rvalid_q           (rvalid_q),
		.right_gain_q       (right_gain_q),
		.output_cfg_q       (output_cfg_q),
		.cfg_q              (cfg_q)
	);

	// Print counts and verdict, then stop
	task automatic give_verdict();
		$display("Counts: %0d compares, %0d errors", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Write one byte; returns once the decode has caught up
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(posedge mclk);
		#1;
		req.wr = 1'b0;
		@(posedge mclk);
		#1;
	endtask

	// Read one byte and compare the answer
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		req.addr = a;
		req.rd = 1'b1;
		@(posedge mclk);
		#1;
		req.rd = 1'b0;
		`CHK(rvalid_q, 1'b1)
		`CHK(rdata_q, e)
		@(posedge mclk);
		#1;
		`CHK(rvalid_q, 1'b0)
	endtask

	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 1000) begin
			err_total++;
			give_verdict();
		end
	end

	// Main sequence
	initial begin
		repeat (3) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		rd(8'h05, 8'hCF);
		rd(8'h06, 8'h51);
		`CHK(cfg_q.gain_half_db, 9'h000)
		`CHK(cfg_q.switch_mult, 5'h10)
		$display("test reset done");
		wr(8'h05, 8'hFF);
		`CHK(cfg_q.gain_half_db, 9'h030)
		wr(8'h05, 8'h07);
		`CHK(cfg_q.gain_half_db, 9'h138)
		`CHK(cfg_q.mute, 1'b0)
		wr(8'h05, 8'h06);
		`CHK(cfg_q.mute, 1'b1)
		rd(8'h05, 8'h06);
		$display("test volume done");
		// Every rate code at both speeds
		for (int s = 0; s < 2; s++) begin
			for (int c = 0; c < 8; c++) begin
				spd = s[0];
				wr(8'h06, {1'b0, c[2:0], 4'h1});
				`CHK(cfg_q.switch_mult, s ? mult[c] >> 1 : mult[c])
				`CHK(cfg_q.double_speed, s[0])
			end
		end
		spd = 1'b0;
		$display("test rate done");
		// Each legal analog gain code
		for (int g = 0; g < 3; g++) begin
			wr(8'h06, {4'h5, g[1:0], 2'h1});
			`CHK(cfg_q.analog_gain, g[1:0])
		end
		$display("test gain done");
		wr(8'h06, 8'hD3);
		`CHK(cfg_q.parallel_mono, 1'b1)
		`CHK(cfg_q.mono_src_left, 1'b1)
		wr(8'h06, 8'h53);
		`CHK(cfg_q.parallel_mono, 1'b0)
		`CHK(cfg_q.mono_src_left, 1'b0)
		wr(8'h06, 8'hD1);
		`CHK(cfg_q.mono_src_left, 1'b0)
		$display("test topology done");
		// Reserved slot leaves the rest untouched
		wr(8'h07, 8'hAA);
		rd(8'h07, 8'h00);
		`CHK(right_gain_q, 8'h06)
		`CHK(output_cfg_q, 8'hD1)
		$display("test reserved done");
		// Reset in mid-run brings both registers back to defaults
		rst_n = 1'b0;
		@(posedge mclk);
		#1;
		rst_n = 1'b1;
		`CHK(right_gain_q, 8'hCF)
		`CHK(output_cfg_q, 8'h51)
		rd(8'h06, 8'h51);
		`CHK(cfg_q.switch_mult, 5'h10)
		$display("test reset again done");
		give_verdict();
	end
endmodule

`undef CHK
`default_nettype wire
